// >>> rtl/tps_fifo.sv
`timescale 1ns/1ps

module tps_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PTR_W:0] FULL_COUNT = (PTR_W + 1)'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH]; // entries, addressed by index
    logic [PTR_W-1:0] wr_idx; // next entry to write
    logic [PTR_W-1:0] rd_idx; // oldest entry
    logic [PTR_W:0] count; // entries held
    logic push; // accepted write
    logic pop; // accepted read

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign out_data = mem[rd_idx];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    ////////////////////////////////////////////////////////////////////////
    // storage: written only on push, so a full fifo never loses data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_idx] <= in_data;
        end
    end

    // write pointer, wraps at the last entry for non power-of-two depths
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_idx <= '0;
        end else if (push) begin
            wr_idx <= (wr_idx == LAST_IDX) ? '0 : wr_idx + 1'b1;
        end
    end

    // read pointer
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_idx <= '0;
        end else if (pop) begin
            rd_idx <= (rd_idx == LAST_IDX) ? '0 : rd_idx + 1'b1;
        end
    end

    // occupancy: push and pop together leave it unchanged
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + 1'b1;
        end else if (pop && !push) begin
            count <= count - 1'b1;
        end
    end

endmodule // tps_fifo

// >>> rtl/tps_pkg.sv
package tps_pkg;

    // serial clock and line rate, in kHz and kb/s as printed
    localparam int unsigned TPS_BIT_CLOCK_KHZ = 4096;
    localparam int unsigned TPS_LINE_RATE_KBPS = 2048;
    // bit-clock cycles per serial data bit, derived from the two rates
    localparam int unsigned TPS_CYC_PER_BIT =
        TPS_BIT_CLOCK_KHZ / TPS_LINE_RATE_KBPS;

    // frame geometry
    localparam int unsigned TPS_SLOTS = 32;
    localparam int unsigned TPS_BITS_PER_SLOT = 8;
    localparam int unsigned TPS_FRAME_CYC =
        TPS_SLOTS * TPS_BITS_PER_SLOT * TPS_CYC_PER_BIT;
    localparam int unsigned TPS_CNT_W = $clog2(TPS_FRAME_CYC);

    // position counter fields: phase, bit, slot
    localparam int unsigned TPS_PHASE_POS = 0;
    localparam int unsigned TPS_BIT_LSB = 1;
    localparam int unsigned TPS_BIT_MSB = 3;
    localparam int unsigned TPS_SLOT_LSB = 4;
    localparam int unsigned TPS_SLOT_MSB = 8;
    // phase in which the inputs are sampled and the outputs shifted
    localparam logic TPS_SAMPLE_PHASE = 1'b1;
    // low counter bits on the last cycle of a slot
    localparam logic [3:0] TPS_SLOT_END = 4'hf;

    // data widths and buffering
    localparam int unsigned TPS_BYTE_W = 8;
    localparam int unsigned TPS_WORD_W = 2 * TPS_BYTE_W;
    localparam int unsigned TPS_FIFO_DEPTH = 4;

    // longest level run, in bit-clock cycles, taken as a frame pulse
    localparam logic [3:0] TPS_PULSE_MAX = 4'h4;
    localparam logic [3:0] TPS_RUN_SAT = 4'hf;

    // detected pulse formats: active low backplane or active high gci
    localparam logic TPS_FMT_LOW_PULSE = 1'b0;
    localparam logic TPS_FMT_HIGH_PULSE = 1'b1;

    // byte sent in a slot for which no data has come back yet
    localparam logic [7:0] TPS_IDLE_BYTE = 8'hff;

    // frame alignment state of the link side
    typedef enum logic {
        TPS_HUNT,
        TPS_LOCKED
    } tps_sync_t;

endpackage

// >>> rtl/tps_serial_port.sv
`timescale 1ns/1ps

// Function
// RULE1 - drivers enabled when pin and bit both high
// RULE2 - outputs high impedance when either enable low
// RULE3 - outputs carry 32 channels at 2.048 Mb/s
// RULE4 - send stream accepted at 2 Mb/s; sampled at 2.048 Mb/s here, like the receive stream
// RULE5 - receive stream sampled at 2.048 Mb/s
// RULE6 - frame pulse format detected automatically
// RULE7 - 4.096 MHz bit clock shifts all streams
// RULE8 - partner sets master clock rate select pin
// RULE9 - master clock asynchronous; port data crosses domains
// RULE10 - 32 eight-bit slots, two clocks per bit
module tps_serial_port
    import tps_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic bit_clock_4m,
    input wire logic frame_pulse_in,
    input wire logic receive_in_stream,
    input wire logic send_in_stream,
    input wire logic output_drive_enable,
    input wire logic ctrl_drive_enable,
    output logic receive_out_stream,
    output logic receive_out_oe,
    output logic send_out_stream,
    output logic send_out_oe,
    output logic frame_locked,
    output logic frame_format,
    output logic tap_valid,
    output logic [TPS_BYTE_W-1:0] tap_receive,
    output logic [TPS_BYTE_W-1:0] tap_send,
    output logic overrun
);

    ////////////////////////////////////////////////////////////////////////
    // link side declarations (bit_clock_4m domain)
    logic [1:0] link_rst_q; // reset synchroniser for the link domain
    logic link_rst_n; // released on a bit-clock edge
    logic fp_q; // previous frame pulse sample
    logic [3:0] run_len; // cycles at the current pulse level
    logic pulse_end; // a short run just ended
    tps_sync_t sync_state; // frame alignment state
    logic [TPS_CNT_W-1:0] pos; // position within the frame
    logic sample_now; // inputs sampled this edge
    logic slot_end; // last edge of a slot
    logic [TPS_BYTE_W-1:0] rin_sh; // receive-side input shifter
    logic [TPS_BYTE_W-1:0] sin_sh; // send-side input shifter
    logic [TPS_WORD_W-1:0] fwd_data; // word offered to the master clock
    logic fwd_req; // toggles once per offered word
    logic [1:0] fwd_ack_sync; // ack toggle from the master side
    logic link_drop; // sticky: a slot found the crossing busy
    logic [1:0] back_req_sync; // return-word toggle from the master side
    logic back_seen; // last return toggle taken, doubles as ack
    logic [TPS_WORD_W-1:0] hold; // returned word waiting for a slot
    logic hold_valid; // hold carries unsent data
    logic [TPS_BYTE_W-1:0] rout_sh; // receive-side output shifter
    logic [TPS_BYTE_W-1:0] sout_sh; // send-side output shifter
    logic [1:0] pin_sync; // drive-enable pin synchroniser
    logic [1:0] ctl_sync; // control bit synchroniser

    ////////////////////////////////////////////////////////////////////////
    // master side declarations (clk domain)
    logic [1:0] fwd_req_sync; // offered-word toggle from the link
    logic fwd_seen; // last offered toggle taken, doubles as ack
    logic fifo_in_valid; // a link word is waiting to enter the fifo
    logic fifo_in_ready; // fifo has room
    logic fifo_out_valid; // fifo holds a word
    logic fifo_out_ready; // return crossing is idle
    logic [TPS_WORD_W-1:0] fifo_out_data; // oldest word
    logic [1:0] back_ack_sync; // return ack toggle from the link
    logic back_req; // toggles once per returned word
    logic [TPS_WORD_W-1:0] back_data; // word handed back to the link
    logic [1:0] drop_sync; // sticky link drop flag, synchronised

    ////////////////////////////////////////////////////////////////////////
    // link reset: asserted at once, released on the bit clock so the
    // frame logic never sees a release in the middle of an edge
    always_ff @(posedge bit_clock_4m or negedge arst_n) begin
        if (!arst_n) begin
            link_rst_q <= 2'h0;
        end else begin
            link_rst_q <= {link_rst_q[0], 1'b1};
        end
    end
    assign link_rst_n = link_rst_q[1];

    ////////////////////////////////////////////////////////////////////////
    // frame pulse run length; the pins are timed to the bit clock,
    // so they are read here without a synchroniser
    assign pulse_end = (frame_pulse_in != fp_q) && (run_len <= TPS_PULSE_MAX);

    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fp_q <= 1'b1;
            run_len <= TPS_RUN_SAT;
        end else begin
            fp_q <= frame_pulse_in;
            if (frame_pulse_in != fp_q) begin
                run_len <= 4'h1;
            end else if (run_len != TPS_RUN_SAT) begin
                run_len <= run_len + 4'h1;
            end
        end
    end

    // format detection: the short run is the pulse, its level the format;
    // a long idle run of either level is never taken for a pulse
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            frame_format <= TPS_FMT_LOW_PULSE;
        end else if (pulse_end) begin
            frame_format <= fp_q ? TPS_FMT_HIGH_PULSE
                                 : TPS_FMT_LOW_PULSE; // RULE6
        end
    end

    // alignment state: hunt until the first recognised pulse
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sync_state <= TPS_HUNT;
        end else begin
            case (sync_state)
                TPS_HUNT: begin
                    if (pulse_end) begin
                        sync_state <= TPS_LOCKED; // RULE6
                    end
                end
                TPS_LOCKED: begin
                    sync_state <= TPS_LOCKED;
                end
                default: begin
                    sync_state <= TPS_HUNT;
                end
            endcase
        end
    end

    // locked flag for the user, from its own flop
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            frame_locked <= 1'b0;
        end else begin
            frame_locked <= (sync_state == TPS_LOCKED) || pulse_end;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame position: the edge that sees the pulse end is cycle 0,
    // every later pulse realigns; free-running wrap after 512 cycles
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            pos <= '0;
        end else if (pulse_end) begin
            pos <= TPS_CNT_W'(1); // RULE10
        end else begin
            pos <= pos + 1'b1; // RULE7 RULE10
        end
    end

    assign sample_now = (sync_state == TPS_LOCKED) && !pulse_end
                        && (pos[TPS_PHASE_POS] == TPS_SAMPLE_PHASE);
    assign slot_end = sample_now
                      && (pos[TPS_BIT_MSB:TPS_PHASE_POS] == TPS_SLOT_END);

    // input shifters, msb first, one sample in the middle of each bit
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rin_sh <= '0;
            sin_sh <= '0;
        end else if (sample_now) begin
            rin_sh <= {rin_sh[TPS_BYTE_W-2:0], receive_in_stream}; // RULE5
            sin_sh <= {sin_sh[TPS_BYTE_W-2:0], send_in_stream}; // RULE4
        end
    end

    // forward crossing: one word per slot, offered only when the master
    // side has acknowledged the last; a busy crossing drops the slot
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fwd_data <= '0;
            fwd_req <= 1'b0;
            link_drop <= 1'b0;
        end else if (slot_end) begin
            if (fwd_req == fwd_ack_sync[1]) begin
                fwd_data <= {rin_sh[TPS_BYTE_W-2:0], receive_in_stream,
                             sin_sh[TPS_BYTE_W-2:0], send_in_stream}; // RULE9
                fwd_req <= ~fwd_req; // RULE9
            end else begin
                link_drop <= 1'b1;
            end
        end
    end

    // ack toggle from the master side, two flops
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            fwd_ack_sync <= 2'h0;
        end else begin
            fwd_ack_sync <= {fwd_ack_sync[0], fwd_seen};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // return crossing: the master side holds back_data steady until
    // back_seen echoes its toggle, so the word is read without a sync
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            back_req_sync <= 2'h0;
        end else begin
            back_req_sync <= {back_req_sync[0], back_req};
        end
    end

    // hold register: filled on a new return word, emptied at slot end;
    // a fill on the emptying edge wins, so no returned word is lost
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            back_seen <= 1'b0;
            hold <= '0;
            hold_valid <= 1'b0;
        end else if (back_req_sync[1] != back_seen) begin
            back_seen <= back_req_sync[1]; // RULE9
            hold <= back_data;
            hold_valid <= 1'b1;
        end else if (slot_end) begin
            hold_valid <= 1'b0;
        end
    end

    // output shifters: loaded at the slot boundary, shifted at each bit
    // boundary; an idle byte fills slots with nothing returned yet
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            rout_sh <= TPS_IDLE_BYTE;
            sout_sh <= TPS_IDLE_BYTE;
        end else if (slot_end) begin
            rout_sh <= hold_valid ? hold[TPS_WORD_W-1:TPS_BYTE_W]
                                  : TPS_IDLE_BYTE; // RULE3
            sout_sh <= hold_valid ? hold[TPS_BYTE_W-1:0]
                                  : TPS_IDLE_BYTE; // RULE3
        end else if (sample_now) begin
            rout_sh <= {rout_sh[TPS_BYTE_W-2:0], 1'b1}; // RULE3 RULE7
            sout_sh <= {sout_sh[TPS_BYTE_W-2:0], 1'b1}; // RULE3 RULE7
        end
    end

    // serial data pins, each from its own flop one cycle behind the shifter
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            receive_out_stream <= 1'b1;
            send_out_stream <= 1'b1;
        end else begin
            receive_out_stream <= rout_sh[TPS_BYTE_W-1]; // RULE3
            send_out_stream <= sout_sh[TPS_BYTE_W-1]; // RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // drive enables: pin and control bit each pass two flops, then
    // the and; either one low releases both drivers
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            pin_sync <= 2'h0;
            ctl_sync <= 2'h0;
        end else begin
            pin_sync <= {pin_sync[0], output_drive_enable};
            ctl_sync <= {ctl_sync[0], ctrl_drive_enable};
        end
    end

    // enables held low during reset so the pins float from the start
    always_ff @(posedge bit_clock_4m or negedge link_rst_n) begin
        if (!link_rst_n) begin
            receive_out_oe <= 1'b0; // RULE2
            send_out_oe <= 1'b0; // RULE2
        end else begin
            receive_out_oe <= pin_sync[1] && ctl_sync[1]; // RULE1 RULE2
            send_out_oe <= pin_sync[1] && ctl_sync[1]; // RULE1 RULE2
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // master side: offered-word toggle, two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fwd_req_sync <= 2'h0;
        end else begin
            fwd_req_sync <= {fwd_req_sync[0], fwd_req};
        end
    end

    // a new toggle is a waiting word; it is acknowledged only when the
    // fifo takes it, which is how a full fifo pushes back on the link
    assign fifo_in_valid = (fwd_req_sync[1] != fwd_seen);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fwd_seen <= 1'b0;
        end else if (fifo_in_valid && fifo_in_ready) begin
            fwd_seen <= fwd_req_sync[1]; // RULE9
        end
    end

    // four-word buffer between the two crossings
    tps_fifo #(
        .WIDTH(TPS_WORD_W),
        .DEPTH(TPS_FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fwd_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // return ack toggle from the link, two flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            back_ack_sync <= 2'h0;
        end else begin
            back_ack_sync <= {back_ack_sync[0], back_seen};
        end
    end

    // the fifo drains only while the return crossing is idle; a stalled
    // link clock therefore stalls the drain and lets the fifo fill
    assign fifo_out_ready = (back_req == back_ack_sync[1]);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            back_req <= 1'b0;
            back_data <= '0;
        end else if (fifo_out_valid && fifo_out_ready) begin
            back_data <= fifo_out_data; // RULE9
            back_req <= ~back_req; // RULE9
        end
    end

    // tap of each word as it leaves the fifo, one-cycle valid pulse
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tap_valid <= 1'b0;
            tap_receive <= '0;
            tap_send <= '0;
        end else begin
            tap_valid <= fifo_out_valid && fifo_out_ready;
            if (fifo_out_valid && fifo_out_ready) begin
                tap_receive <= fifo_out_data[TPS_WORD_W-1:TPS_BYTE_W];
                tap_send <= fifo_out_data[TPS_BYTE_W-1:0];
            end
        end
    end

    // sticky drop flag from the link: level crossing by two flops,
    // then a third so the output comes from a flop of its own
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drop_sync <= 2'h0;
            overrun <= 1'b0;
        end else begin
            drop_sync <= {drop_sync[0], link_drop};
            overrun <= drop_sync[1];
        end
    end

endmodule // tps_serial_port

// >>> verif/tb_tdm_pcm_serial_port.sv
`timescale 1ns/1ps

// bench: framer model on the link
module tb_tdm_pcm_serial_port;
    logic clk = 1'b0;
    logic bit_clock_4m = 1'b0;
    logic arst_n = 1'b0;
    logic drv_pin = 1'b0; // drive-enable pin
    logic drv_bit = 1'b0; // control register enable bit
    logic run = 1'b0; // framer active
    logic fmt = 1'b1; // framer pulse style
    logic fp, rin, sin, rout, roe, sout, soe, locked, fmt_seen, tv, ovr;
    logic [7:0] tap_r, tap_s;
    logic [15:0] good, bad;
    tri1 rx_line; // pull-up for a released line
    tri1 tx_line;
    int n_errors = 0;
    int num_checks = 0;
    ////////////////////////////////////////////////////////////////
    // master clock, 40 ns
    always #20 clk = ~clk;
    // link clock, 32 ns, off the clk edges
    initial #5 forever #16 bit_clock_4m = ~bit_clock_4m;
    assign rx_line = roe ? rout : 1'bz;
    assign tx_line = soe ? sout : 1'bz;
    tps_serial_port DUT (.clk(clk), .arst_n(arst_n),
        .bit_clock_4m(bit_clock_4m), .frame_pulse_in(fp),
        .receive_in_stream(rin), .send_in_stream(sin),
        .output_drive_enable(drv_pin), .ctrl_drive_enable(drv_bit),
        .receive_out_stream(rout), .receive_out_oe(roe),
        .send_out_stream(sout), .send_out_oe(soe), .frame_locked(locked),
        .frame_format(fmt_seen), .tap_valid(tv), .tap_receive(tap_r),
        .tap_send(tap_s), .overrun(ovr));
    tps_framer_model u_far (.bit_clock_4m(bit_clock_4m), .run(run),
        .fmt_high(fmt), .rx_line(rx_line), .tx_line(tx_line),
        .frame_pulse_in(fp), .receive_in_stream(rin),
        .send_in_stream(sin), .good(good), .bad(bad));
    ////////////////////////////////////////////////////////////////
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t bit %b want %b", $time, got, exp);
        end
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t byte %h want %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // framer stops first: no pulse in the release window
    task automatic do_reset;
        run = 1'b0;
        arst_n = 1'b0;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////
    // every pin and bit combination, past the sync delay
    task automatic t_enables;
        for (int i = 0; i < 4; i++) begin
            drv_pin = i[1];
            drv_bit = i[0];
            repeat (6) @(negedge clk);
            chk1(roe, i == 3);
            chk1(soe, i == 3);
        end
    endtask
    // lock on one pulse style, then three frames of loopback
    task automatic t_stream(input logic f);
        int i, g0;
        fmt = f;
        g0 = good;
        do_reset();
        run = 1'b1;
        for (i = 0; i < 2000 && locked !== 1'b1; i++) @(negedge clk);
        chk1(locked, 1'b1);
        chk1(fmt_seen, f);
        repeat (1300) @(negedge clk);
        chk1(bad === 16'h0, 1'b1);
        chk1(good - g0 > 60, 1'b1);
        chk1(ovr, 1'b0);
        for (i = 0; i < 200 && tv !== 1'b1; i++) @(negedge clk);
        chk1(tv, 1'b1);
        chk8(tap_r & 8'he0, 8'ha0);
        chk8(tap_s, {3'h0, tap_r[4:0] ^ 5'h05} + 8'h3c);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        t_enables();
        t_stream(1'b1);
        t_stream(1'b0);
        end_of_test();
    end
    // run needs ~0.14 ms; cut a hang short
    initial begin
        #600000;
        n_errors++;
        end_of_test();
    end
endmodule // tb_tdm_pcm_serial_port

// >>> verif/tps_framer_model.sv
`timescale 1ns/1ps

// far-side framer: frames both inputs, judges what loops back
module tps_framer_model (
    input wire logic bit_clock_4m,
    input wire logic run,
    input wire logic fmt_high,
    input wire logic rx_line,
    input wire logic tx_line,
    output logic frame_pulse_in,
    output logic receive_in_stream,
    output logic send_in_stream,
    output logic [15:0] good,
    output logic [15:0] bad
);
    // master clock 25 MHz, so rate select stays low
    localparam logic RATE_SEL = 1'b0;
    logic [8:0] pos = 9'h0; // bit-clock cycle inside the frame
    logic tog = 1'b0; // filler that moves every cycle
    logic have = 1'b0; // a slot has been seen since framing began
    logic [4:0] last, s;
    logic [7:0] rxb, txb, rsh, tsh, rb, tb;
    initial good = 16'h0;
    initial bad = 16'h0;
    ////////////////////////////////////////////////////////////////
    // lines move on the falling edge, clear of the sampling edge
    always @(negedge bit_clock_4m) begin
        tog <= ~tog;
        pos <= run ? pos + 9'h1 : 9'h0;
    end
    // slot number in two codings, so a slip or a swap shows
    assign rxb = {3'h5, pos[8:4] ^ 5'h05};
    assign txb = {3'h0, pos[8:4]} + 8'h3c;
    // one-cycle pulse before cycle 0; idle at the other level
    assign frame_pulse_in = (run && pos == 9'h1ff) ? fmt_high : ~fmt_high;
    assign receive_in_stream = run ? rxb[3'h7 - pos[3:1]] : tog;
    assign send_in_stream = run ? txb[3'h7 - pos[3:1]] : ~tog;
    ////////////////////////////////////////////////////////////////
    // returned bits taken mid-bit; idle bytes are skipped
    always @(posedge bit_clock_4m) begin
        rb = {rsh[6:0], rx_line};
        tb = {tsh[6:0], tx_line};
        s = rb[4:0] ^ 5'h05;
        if (!run) begin
            have <= 1'b0;
        end else if (pos[0]) begin
            rsh <= rb;
            tsh <= tb;
            if (pos[3:0] == 4'hf && rb != 8'hff) begin
                have <= 1'b1;
                last <= s;
                // wrong coding, unpaired bytes or a skipped slot
                if (rb[7:5] != 3'h5 || tb != {3'h0, s} + 8'h3c
                    || (have && s != last + 5'h1)) begin
                    bad <= bad + 16'h1;
                end else begin
                    good <= good + 16'h1;
                end
            end
        end
    end
endmodule // tps_framer_model

// >>> verif/tps_serial_port_assertions.sv
`timescale 1ns/1ps

// pin checks, both clock domains
module tps_serial_port_assertions
    import tps_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic bit_clock_4m,
    input wire logic frame_pulse_in,
    input wire logic output_drive_enable,
    input wire logic ctrl_drive_enable,
    input wire logic receive_out_stream,
    input wire logic receive_out_oe,
    input wire logic send_out_stream,
    input wire logic send_out_oe,
    input wire logic frame_locked,
    input wire logic frame_format,
    input wire logic tap_valid,
    input wire logic [TPS_BYTE_W-1:0] tap_receive,
    input wire logic [TPS_BYTE_W-1:0] tap_send,
    input wire logic overrun
);
    // link side leaves reset late, so its checks wait a while
    logic [3:0] age;
    logic ok;
    always_ff @(posedge bit_clock_4m or negedge arst_n) begin
        if (!arst_n) begin
            age <= 4'h0;
        end else if (age != 4'hf) begin
            age <= age + 4'h1;
        end
    end
    assign ok = (age == 4'hf);
    ////////////////////////////////////////////////////////////////
    a_oe_both_high: assert property (@(posedge bit_clock_4m)
        disable iff (!arst_n)
        (ok && output_drive_enable && ctrl_drive_enable)[*3]
        |=> receive_out_oe && send_out_oe)
        else $error("oe low, enables high");
    a_oe_off_hiz: assert property (@(posedge bit_clock_4m)
        disable iff (!arst_n)
        (ok && !(output_drive_enable && ctrl_drive_enable))[*3]
        |=> !receive_out_oe && !send_out_oe)
        else $error("oe high, enable low");
    a_oe_same: assert property (@(posedge bit_clock_4m)
        disable iff (!arst_n) ok |-> receive_out_oe == send_out_oe)
        else $error("oe differ");
    a_idle_unlocked: assert property (@(posedge bit_clock_4m)
        disable iff (!arst_n) ok && !frame_locked
        |-> receive_out_stream && send_out_stream)
        else $error("busy before lock");
    a_bit_two_cyc: assert property (@(posedge bit_clock_4m)
        disable iff (!arst_n) ok && ($changed(receive_out_stream)
        || $changed(send_out_stream)) |=> $stable(receive_out_stream)
        && $stable(send_out_stream))
        else $error("short output bit");
    a_lock_holds: assert property (@(posedge bit_clock_4m)
        disable iff (!arst_n) frame_locked |=> frame_locked)
        else $error("frame lock lost");
    a_lock_on_pulse: assert property (@(posedge bit_clock_4m)
        disable iff (!arst_n) ok && $rose(frame_locked)
        |-> $past(frame_pulse_in, 1) != $past(frame_pulse_in, 2))
        else $error("lock without pulse");
    a_fmt_level: assert property (@(posedge bit_clock_4m)
        disable iff (!arst_n) ok && $rose(frame_locked)
        |-> frame_format == $past(frame_pulse_in, 2))
        else $error("wrong pulse style");
    a_tap_hold: assert property (@(posedge clk)
        disable iff (!arst_n) !tap_valid
        |-> $stable(tap_receive) && $stable(tap_send))
        else $error("tap moved idle");
    a_ovr_sticky: assert property (@(posedge clk)
        disable iff (!arst_n) overrun |=> overrun)
        else $error("overrun cleared");
    // main scenarios reached
    c_gci: cover property (@(posedge bit_clock_4m)
        frame_locked && frame_format);
    c_low: cover property (@(posedge bit_clock_4m)
        frame_locked && !frame_format);
    c_tap: cover property (@(posedge clk) tap_valid);
endmodule // tps_serial_port_assertions

bind tps_serial_port tps_serial_port_assertions u_chk (.*);
